// ---- hw/vbl_pkg.sv ----
// shared constants, encodings and carriers for the value block and sector login handler
package vbl_pkg;

	// command characters taken from the serial link
	localparam logic [7:0] CH_INC      = 8'h2B;
	localparam logic [7:0] CH_DEC      = 8'h2D;
	localparam logic [7:0] CH_COPY     = 8'h3D;
	localparam logic [7:0] CH_LOGIN_LC = 8'h6C;
	localparam logic [7:0] CH_LOGIN_UC = 8'h4C;
	localparam logic [7:0] CH_CR       = 8'h0D;

	// ascii codes used by the hex codec
	localparam logic [7:0] CH_0  = 8'h30;
	localparam logic [7:0] CH_9  = 8'h39;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UF = 8'h46;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LF = 8'h66;
	localparam logic [7:0] HEX_TEN = 8'h0A;

	// single character answers
	localparam logic [7:0] RSP_LOGIN_OK  = 8'h4C;
	localparam logic [7:0] RSP_AUTH_FAIL = 8'h58;
	localparam logic [7:0] RSP_FAIL      = 8'h46;
	localparam logic [7:0] RSP_NO_TAG    = 8'h4E;
	localparam logic [7:0] RSP_OP_MODE   = 8'h4F;
	localparam logic [7:0] RSP_RANGE     = 8'h52;
	localparam logic [7:0] RSP_NO_VALUE  = 8'h49;

	// login parameter ranges and key type codes
	localparam logic [7:0] SECTOR_MAX   = 8'h3F;
	localparam logic [7:0] KT_KEY_A     = 8'hAA;
	localparam logic [7:0] KT_KEY_B     = 8'hBB;
	localparam logic [7:0] KT_ONES_A    = 8'hFF;
	localparam logic [7:0] KT_STORE_A   = 8'h10;
	localparam logic [7:0] KT_STORE_A_H = 8'h2F;
	localparam logic [7:0] KT_STORE_B   = 8'h30;
	localparam logic [7:0] KT_STORE_B_H = 8'h4F;

	// built-in transport keys, first key byte in the top bits
	localparam logic [47:0] TKEY_A    = 48'hA0A1A2A3A4A5;
	localparam logic [47:0] TKEY_B    = 48'hB0B1B2B3B4B5;
	localparam logic [47:0] TKEY_ONES = 48'hFFFFFFFFFFFF;

	// parameter byte counts and reply lengths
	localparam logic [3:0] NPAR_VALUE = 4'h5;
	localparam logic [3:0] NPAR_COPY  = 4'h2;
	localparam logic [3:0] NPAR_HDR   = 4'h2;
	localparam logic [3:0] NPAR_KEY   = 4'h8;
	localparam logic [3:0] LEN_VALUE  = 4'h8;
	localparam logic [3:0] LEN_CHAR   = 4'h1;

	// value block layout: value, inverted value, value, then address bytes
	localparam int VB_VAL0 = 0;
	localparam int VB_INV  = 32;
	localparam int VB_VAL1 = 64;
	localparam int VB_ADR  = 96;

	// reset values
	localparam logic [5:0] RESET_SECTOR = 6'h00;

	typedef enum logic [1:0] {
		CMD_INC   = 2'b00,
		CMD_DEC   = 2'b01,
		CMD_COPY  = 2'b10,
		CMD_LOGIN = 2'b11
	} cmd_e;

	typedef enum logic [1:0] {
		OP_AUTH  = 2'b00,
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10
	} card_op_e;

	typedef enum logic [2:0] {
		CS_OK        = 3'b000,
		CS_NO_TAG    = 3'b001,
		CS_NOT_A     = 3'b010,
		CS_FAIL      = 3'b011,
		CS_AUTH_FAIL = 3'b100
	} card_status_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} char_s;

	typedef struct packed {
		logic         valid;
		card_op_e     op;
		logic [7:0]   block;
		logic         key_b;
		logic         key_stored;
		logic [4:0]   key_index;
		logic [47:0]  key;
		logic [127:0] wdata;
	} card_req_s;

	typedef struct packed {
		logic         valid;
		card_status_e status;
		logic [127:0] rdata;
	} card_rsp_s;

	typedef struct packed {
		logic       valid;
		logic [5:0] sector;
	} login_s;

endpackage

// ---- hw/hex_pair_collector.sv ----
// joins pairs of ascii hex characters into parameter bytes
`timescale 1ns/1ns
module hex_pair_collector (
	input  wire logic            i_clk,
	input  wire logic            i_resetn,
	input  wire logic            i_clear,
	input  vbl_pkg::char_s       i_char,
	output vbl_pkg::char_s       o_byte,
	output vbl_pkg::char_s       o_other
);
	import vbl_pkg::*;

	logic       have_hi;
	logic [3:0] hi;
	logic       is_hex;
	logic [3:0] nib;

	// decode one ascii character into a nibble
	always_comb
	begin
		is_hex = 1'b0;
		nib    = 4'h0;
		if (i_char.data >= CH_0 && i_char.data <= CH_9)
		begin
			is_hex = 1'b1;
			nib    = 4'(i_char.data - CH_0);
		end
		else if (i_char.data >= CH_UA && i_char.data <= CH_UF)
		begin
			is_hex = 1'b1;
			nib    = 4'(i_char.data - CH_UA + HEX_TEN);
		end
		else if (i_char.data >= CH_LA && i_char.data <= CH_LF)
		begin
			is_hex = 1'b1;
			nib    = 4'(i_char.data - CH_LA + HEX_TEN);
		end
	end

	// high nibble first, byte pulse on the second character
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			have_hi <= 1'b0;
			hi      <= 4'h0;
			o_byte  <= '0;
			o_other <= '0;
		end
		else
		begin
			o_byte.valid  <= 1'b0;
			o_other.valid <= 1'b0;
			if (i_clear)
				have_hi <= 1'b0;
			else if (i_char.valid)
			begin
				if (is_hex && have_hi)
				begin
					o_byte.valid <= 1'b1;
					o_byte.data  <= {hi, nib};
					have_hi      <= 1'b0;
				end
				else if (is_hex)
				begin
					hi      <= nib;
					have_hi <= 1'b1;
				end
				else
				begin
					o_other.valid <= 1'b1; // separator or terminator
					o_other.data  <= i_char.data;
					have_hi       <= 1'b0;
				end
			end
		end
	end

endmodule

// ---- hw/value_block_and_sector_login.sv ----
// text command handler for value block increment, decrement, copy and sector login
`timescale 1ns/1ns

// Overview of operation
// RQ1 - increment: block, four byte amount, returns value
// RQ2 - read back every value write to verify
// RQ3 - non-value source on increment/decrement replies I
// RQ4 - host logs into sector before value commands
// RQ5 - increment or its read-back fails replies F
// RQ6 - decrement: block, four byte amount, returns value
// RQ7 - decrement or its read-back fails replies F
// RQ8 - copy: source, target, returns target value
// RQ9 - copy target need not be value block
// RQ10 - non-value copy source replies I
// RQ11 - copy or its read-back fails replies F
// RQ12 - only one sector authenticated at once
// RQ13 - sector above 3Fh or bad key type: R
// RQ14 - AAh key A, BBh key B, supplied key
// RQ15 - FFh means key A with all-ones key
// RQ16 - 10h-2Fh/30h-4Fh use stored key A/B
// RQ17 - six key bytes or CR for transport key
// RQ18 - login answers L on success, X rejected
// RQ19 - three fixed transport keys chosen by key type
// RQ20 - card not type A replies O
// RQ21 - absent or silent card replies N
// RQ22 - parameters are hex pairs without separators
module value_block_and_sector_login (
	input  wire logic            i_clk,
	input  wire logic            i_resetn,
	input  vbl_pkg::char_s       i_rx,
	output logic                 o_rx_ready,
	output vbl_pkg::char_s       o_tx,
	input  wire logic            i_tx_ready,
	output vbl_pkg::card_req_s   o_card_req,
	input  vbl_pkg::card_rsp_s   i_card_rsp,
	output vbl_pkg::login_s      o_login
);
	import vbl_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_PARAM   = 3'b001,
		S_AUTH    = 3'b010,
		S_RD_SRC  = 3'b011,
		S_WRITE   = 3'b100,
		S_RD_BACK = 3'b101,
		S_REPLY   = 3'b110
	} state_e;

	logic          rst_meta;
	logic          rst_n;
	state_e        st;
	cmd_e          cmd;
	logic [63:0]   pbuf;
	logic [3:0]    pcnt;
	logic [7:0]    tgt_block;
	logic [31:0]   new_value;
	logic [127:0]  wr_block;
	logic [63:0]   rbuf;
	logic [3:0]    rcnt;
	char_s         par_byte;
	char_s         par_other;
	char_s         col_in;
	logic          col_clear;
	logic [7:0]    hdr_sector;
	logic [7:0]    hdr_ktype;
	logic          kt_supplied;
	logic          kt_stored_a;
	logic          kt_stored_b;

	// release the asynchronous reset through two flip-flops
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// parameter characters reach the hex collector only while collecting
	assign col_in.valid = i_rx.valid && o_rx_ready && (st == S_PARAM);
	assign col_in.data  = i_rx.data;
	assign col_clear    = (st != S_PARAM);

	hex_pair_collector u_hex (
		.i_clk    (i_clk),
		.i_resetn (rst_n),
		.i_clear  (col_clear),
		.i_char   (col_in),
		.o_byte   (par_byte),
		.o_other  (par_other)
	); // [RQ22]

	// login header fields and key type classes
	assign hdr_sector  = pbuf[15:8];
	assign hdr_ktype   = pbuf[7:0];
	assign kt_supplied = (hdr_ktype == KT_KEY_A) || (hdr_ktype == KT_KEY_B)
		|| (hdr_ktype == KT_ONES_A); // [RQ14] [RQ15]
	assign kt_stored_a = (hdr_ktype >= KT_STORE_A) && (hdr_ktype <= KT_STORE_A_H); // [RQ16]
	assign kt_stored_b = (hdr_ktype >= KT_STORE_B) && (hdr_ktype <= KT_STORE_B_H); // [RQ16]

	// true when a 16 byte block holds a well formed value
	function automatic logic is_value(input logic [127:0] b);
		logic [31:0] v;
		v = b[VB_VAL0 +: 32];
		is_value = (b[VB_INV +: 32] == ~v) && (b[VB_VAL1 +: 32] == v)
			&& (b[VB_ADR +: 8] == ~b[VB_ADR + 8 +: 8])
			&& (b[VB_ADR +: 8] == b[VB_ADR + 16 +: 8])
			&& (b[VB_ADR + 8 +: 8] == ~b[VB_ADR + 16 +: 8])
			&& (b[VB_ADR +: 8] == ~b[VB_ADR + 24 +: 8]);
	endfunction

	// build a value block image for a given value and address byte
	function automatic logic [127:0] make_value(input logic [31:0] v, input logic [7:0] a);
		make_value = {~a, a, ~a, a, v, ~v, v};
	endfunction

	// ascii hex digit for one nibble
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		if (n < 4'hA)
			hex_char = CH_0 + {4'h0, n};
		else
			hex_char = CH_UA + {4'h0, n} - HEX_TEN;
	endfunction

	// eight hex characters, most significant nibble first
	function automatic logic [63:0] hex_word(input logic [31:0] v);
		for (int i = 0; i < 8; i++)
			hex_word[8*i +: 8] = hex_char(v[4*i +: 4]);
	endfunction

	// error character for a card status other than ok
	function automatic logic [7:0] err_char(input card_status_e s);
		case (s)
			CS_NO_TAG: err_char = RSP_NO_TAG;  // [RQ21]
			CS_NOT_A:  err_char = RSP_OP_MODE; // [RQ20]
			default:   err_char = RSP_FAIL;    // [RQ5] [RQ7] [RQ11]
		endcase
	endfunction

	// command sequencer, card requests and reply serializer
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st         <= S_IDLE;
			cmd        <= CMD_INC;
			pbuf       <= '0;
			pcnt       <= 4'h0;
			tgt_block  <= 8'h00;
			new_value  <= 32'h00000000;
			wr_block   <= '0;
			rbuf       <= '0;
			rcnt       <= 4'h0;
			o_rx_ready <= 1'b0;
			o_tx       <= '0;
			o_card_req <= '0;
		end
		else
		begin
			o_card_req.valid <= 1'b0;
			case (st)
				S_IDLE:
				begin
					o_rx_ready <= 1'b1;
					pcnt       <= 4'h0;
					if (i_rx.valid && o_rx_ready)
					begin
						if (i_rx.data == CH_INC || i_rx.data == CH_DEC)
						begin
							cmd <= (i_rx.data == CH_INC) ? CMD_INC : CMD_DEC;
							st  <= S_PARAM;
						end
						else if (i_rx.data == CH_COPY)
						begin
							cmd <= CMD_COPY;
							st  <= S_PARAM;
						end
						else if (i_rx.data == CH_LOGIN_LC || i_rx.data == CH_LOGIN_UC)
						begin
							cmd <= CMD_LOGIN;
							st  <= S_PARAM;
						end
					end
				end
				S_PARAM:
				begin
					if (par_byte.valid)
					begin
						pbuf <= {pbuf[55:0], par_byte.data}; // [RQ22]
						pcnt <= pcnt + 4'h1;
					end
					else if (par_other.valid)
					begin
						if (cmd == CMD_LOGIN && pcnt == NPAR_HDR
							&& par_other.data == CH_CR && kt_supplied)
						begin
							// carriage return selects the transport key
							o_rx_ready            <= 1'b0;
							o_card_req.valid      <= 1'b1; // [RQ17]
							o_card_req.op         <= OP_AUTH;
							o_card_req.block      <= hdr_sector;
							o_card_req.key_b      <= (hdr_ktype == KT_KEY_B);
							o_card_req.key_stored <= 1'b0;
							o_card_req.key_index  <= 5'h00;
							if (hdr_ktype == KT_KEY_A)
								o_card_req.key <= TKEY_A; // [RQ19]
							else if (hdr_ktype == KT_KEY_B)
								o_card_req.key <= TKEY_B; // [RQ19]
							else
								o_card_req.key <= TKEY_ONES; // [RQ19] [RQ15]
							st <= S_AUTH;
						end
						else
						begin
							o_rx_ready <= 1'b0; // malformed line is dropped
							st         <= S_IDLE;
						end
					end
					else if ((cmd == CMD_INC || cmd == CMD_DEC) && pcnt == NPAR_VALUE)
					begin
						// block in byte 4, amount sent most significant first
						o_rx_ready       <= 1'b0;
						tgt_block        <= pbuf[39:32];
						o_card_req.valid <= 1'b1; // [RQ1] [RQ6]
						o_card_req.op    <= OP_READ;
						o_card_req.block <= pbuf[39:32];
						st               <= S_RD_SRC;
					end
					else if (cmd == CMD_COPY && pcnt == NPAR_COPY)
					begin
						o_rx_ready       <= 1'b0;
						tgt_block        <= pbuf[7:0];
						o_card_req.valid <= 1'b1; // [RQ8]
						o_card_req.op    <= OP_READ;
						o_card_req.block <= pbuf[15:8];
						st               <= S_RD_SRC;
					end
					else if (cmd == CMD_LOGIN && pcnt == NPAR_HDR
						&& (hdr_sector > SECTOR_MAX
						|| !(kt_supplied || kt_stored_a || kt_stored_b)))
					begin
						o_rx_ready <= 1'b0;
						rbuf       <= {RSP_RANGE, 56'h0}; // [RQ13]
						rcnt       <= LEN_CHAR;
						st         <= S_REPLY;
					end
					else if (cmd == CMD_LOGIN && pcnt == NPAR_HDR
						&& (kt_stored_a || kt_stored_b))
					begin
						o_rx_ready            <= 1'b0;
						o_card_req.valid      <= 1'b1;
						o_card_req.op         <= OP_AUTH;
						o_card_req.block      <= hdr_sector;
						o_card_req.key_b      <= kt_stored_b; // [RQ16]
						o_card_req.key_stored <= 1'b1;
						o_card_req.key_index  <= kt_stored_b
							? 5'(hdr_ktype - KT_STORE_B) : 5'(hdr_ktype - KT_STORE_A);
						o_card_req.key        <= 48'h000000000000;
						st                    <= S_AUTH;
					end
					else if (cmd == CMD_LOGIN && pcnt == NPAR_KEY)
					begin
						// sector, key type, then six supplied key bytes
						o_rx_ready            <= 1'b0;
						o_card_req.valid      <= 1'b1; // [RQ17]
						o_card_req.op         <= OP_AUTH;
						o_card_req.block      <= pbuf[63:56];
						o_card_req.key_b      <= (pbuf[55:48] == KT_KEY_B); // [RQ14]
						o_card_req.key_stored <= 1'b0;
						o_card_req.key_index  <= 5'h00;
						o_card_req.key        <= pbuf[47:0];
						st                    <= S_AUTH;
					end
				end
				S_AUTH:
				begin
					if (i_card_rsp.valid)
					begin
						rcnt <= LEN_CHAR;
						st   <= S_REPLY;
						if (i_card_rsp.status == CS_OK)
							rbuf <= {RSP_LOGIN_OK, 56'h0}; // [RQ18]
						else if (i_card_rsp.status == CS_AUTH_FAIL)
							rbuf <= {RSP_AUTH_FAIL, 56'h0}; // [RQ18]
						else
							rbuf <= {err_char(i_card_rsp.status), 56'h0};
					end
				end
				S_RD_SRC:
				begin
					if (i_card_rsp.valid)
					begin
						if (i_card_rsp.status != CS_OK)
						begin
							rbuf <= {err_char(i_card_rsp.status), 56'h0};
							rcnt <= LEN_CHAR;
							st   <= S_REPLY;
						end
						else if (!is_value(i_card_rsp.rdata))
						begin
							rbuf <= {RSP_NO_VALUE, 56'h0}; // [RQ3] [RQ10]
							rcnt <= LEN_CHAR;
							st   <= S_REPLY;
						end
						else
						begin
							// target gets its own block number as address byte, whatever it held
							o_card_req.valid <= 1'b1; // [RQ9]
							o_card_req.op    <= OP_WRITE;
							o_card_req.block <= tgt_block;
							case (cmd)
								CMD_INC:
								begin
									new_value <= i_card_rsp.rdata[31:0] + pbuf[31:0]; // [RQ1]
									o_card_req.wdata <= make_value(
										i_card_rsp.rdata[31:0] + pbuf[31:0], tgt_block);
									wr_block <= make_value(
										i_card_rsp.rdata[31:0] + pbuf[31:0], tgt_block);
								end
								CMD_DEC:
								begin
									new_value <= i_card_rsp.rdata[31:0] - pbuf[31:0]; // [RQ6]
									o_card_req.wdata <= make_value(
										i_card_rsp.rdata[31:0] - pbuf[31:0], tgt_block);
									wr_block <= make_value(
										i_card_rsp.rdata[31:0] - pbuf[31:0], tgt_block);
								end
								default:
								begin
									new_value        <= i_card_rsp.rdata[31:0]; // [RQ8]
									o_card_req.wdata <= make_value(i_card_rsp.rdata[31:0],
										tgt_block);
									wr_block         <= make_value(i_card_rsp.rdata[31:0],
										tgt_block);
								end
							endcase
							st <= S_WRITE;
						end
					end
				end
				S_WRITE:
				begin
					if (i_card_rsp.valid)
					begin
						if (i_card_rsp.status == CS_OK)
						begin
							o_card_req.valid <= 1'b1; // [RQ2]
							o_card_req.op    <= OP_READ;
							o_card_req.block <= tgt_block;
							st               <= S_RD_BACK;
						end
						else
						begin
							rbuf <= {err_char(i_card_rsp.status), 56'h0};
							rcnt <= LEN_CHAR;
							st   <= S_REPLY;
						end
					end
				end
				S_RD_BACK:
				begin
					if (i_card_rsp.valid)
					begin
						rcnt <= LEN_VALUE;
						st   <= S_REPLY;
						if (i_card_rsp.status == CS_OK && i_card_rsp.rdata == wr_block)
							rbuf <= hex_word(new_value); // [RQ2]
						else if (i_card_rsp.status == CS_NO_TAG
							|| i_card_rsp.status == CS_NOT_A)
						begin
							rbuf <= {err_char(i_card_rsp.status), 56'h0};
							rcnt <= LEN_CHAR;
						end
						else
						begin
							rbuf <= {RSP_FAIL, 56'h0}; // [RQ5] [RQ7] [RQ11]
							rcnt <= LEN_CHAR;
						end
					end
				end
				S_REPLY:
				begin
					if (!o_tx.valid || i_tx_ready)
					begin
						if (rcnt != 4'h0)
						begin
							o_tx.valid <= 1'b1;
							o_tx.data  <= rbuf[63:56];
							rbuf       <= {rbuf[55:0], 8'h00};
							rcnt       <= rcnt - 4'h1;
						end
						else
						begin
							o_tx.valid <= 1'b0;
							st         <= S_IDLE;
						end
					end
				end
				default:
				begin
					st <= S_IDLE;
				end
			endcase
		end
	end

	// single authenticated sector, dropped when a new login request goes to the card
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_login.valid  <= 1'b0;
			o_login.sector <= RESET_SECTOR;
		end
		else if (o_card_req.valid && o_card_req.op == OP_AUTH)
		begin
			o_login.valid  <= 1'b0; // [RQ12]
			o_login.sector <= o_card_req.block[5:0];
		end
		else if (st == S_AUTH && i_card_rsp.valid && i_card_rsp.status == CS_OK)
			o_login.valid <= 1'b1; // [RQ12]
	end

endmodule

// ---- dv/vbl_assertions.sv ----
// concurrent checks on the ports of the value block and sector login handler
`timescale 1ns/1ns
module vbl_assertions
	import vbl_pkg::*;
(
	input wire logic          i_clk,
	input wire logic          i_resetn,
	input wire logic          o_rx_ready,
	input vbl_pkg::char_s     o_tx,
	input wire logic          i_tx_ready,
	input vbl_pkg::card_req_s o_card_req,
	input vbl_pkg::card_rsp_s i_card_rsp,
	input vbl_pkg::login_s    o_login
);
	card_op_e   last_op;
	logic [7:0] last_blk;
	logic       busy;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// remembers the card request in flight
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			last_op  <= OP_AUTH;
			last_blk <= 8'h00;
			busy     <= 1'b0;
		end
		else if (o_card_req.valid)
		begin
			last_op  <= o_card_req.op;
			last_blk <= o_card_req.block;
			busy     <= 1'b1;
		end
		else if (i_card_rsp.valid)
			busy <= 1'b0;
	end

	tx_hold_a: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data))
		else $error("reply char changed before it was taken");
	one_request_a: assert property (o_card_req.valid |-> !busy)
		else $error("second card request while one is open");
	read_back_a: assert property (
		i_card_rsp.valid && i_card_rsp.status == CS_OK && last_op == OP_WRITE
		|=> o_card_req.valid && o_card_req.op == OP_READ && o_card_req.block == last_blk)
		else $error("accepted write not followed by read back");
	rx_closed_a: assert property (o_card_req.valid |-> !o_rx_ready)
		else $error("serial input open during card exchange");
	login_drop_a: assert property (
		o_card_req.valid && o_card_req.op == OP_AUTH |=> ##[0:1] !o_login.valid)
		else $error("old sector still open after new login");
	login_set_a: assert property (
		i_card_rsp.valid && i_card_rsp.status == CS_OK && last_op == OP_AUTH
		|=> ##[0:1] o_login.valid && o_login.sector == last_blk[5:0])
		else $error("login success not reported");
	auth_fail_a: assert property (
		i_card_rsp.valid && i_card_rsp.status == CS_AUTH_FAIL && last_op == OP_AUTH
		|-> ##[1:3] o_tx.valid && o_tx.data == RSP_AUTH_FAIL)
		else $error("rejected key not answered");
	no_tag_a: assert property (
		i_card_rsp.valid && i_card_rsp.status == CS_NO_TAG
		|-> ##[1:3] o_tx.valid && o_tx.data == RSP_NO_TAG)
		else $error("missing card not answered");
	op_mode_a: assert property (
		i_card_rsp.valid && i_card_rsp.status == CS_NOT_A
		|-> ##[1:3] o_tx.valid && o_tx.data == RSP_OP_MODE)
		else $error("wrong card type not answered");
	sector_range_a: assert property (
		o_card_req.valid && o_card_req.op == OP_AUTH |-> o_card_req.block <= SECTOR_MAX)
		else $error("login request for a sector past the top");
endmodule

bind value_block_and_sector_login vbl_assertions i_chk (.i_clk(i_clk), .i_resetn(i_resetn),
	.o_rx_ready(o_rx_ready), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_card_req(o_card_req),
	.i_card_rsp(i_card_rsp), .o_login(o_login));

// ---- dv/card_model.sv ----
// behavioural card answering login, read and write requests
`timescale 1ns/1ns
module card_model
	import vbl_pkg::*;
(
	input  wire logic            i_clk,
	input  vbl_pkg::card_req_s   i_req,
	output vbl_pkg::card_rsp_s   o_rsp,
	input  wire logic [7:0]      i_delay,
	input  vbl_pkg::card_status_e i_status,
	input  wire logic            i_corrupt
);
	logic [127:0] mem [256];
	card_req_s    last;
	int           nreq;

	// one answer per request, after a chosen number of cycles
	initial
	begin
		o_rsp = '0;
		nreq  = 0;
		forever
		begin
			@(posedge i_clk);
			if (i_req.valid)
			begin
				last = i_req;
				nreq++;
				repeat (i_delay) @(posedge i_clk);
				#1;
				o_rsp.valid  = 1'b1;
				o_rsp.status = i_status;
				// a write lands only when accepted; corrupt flips one stored bit
				if (last.op == OP_WRITE && i_status == CS_OK)
					mem[last.block] = last.wdata ^ {127'h0, i_corrupt};
				o_rsp.rdata = (last.op == OP_READ) ? mem[last.block] : ~o_rsp.rdata;
				@(posedge i_clk);
				#1;
				o_rsp.valid = 1'b0;
				o_rsp.rdata = ~o_rsp.rdata; // stale data is the inverse of the answer just given
			end
		end
	end
endmodule

// ---- dv/value_block_and_sector_login_test.sv ----
// self-checking bench for the value block and sector login handler
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module value_block_and_sector_login_test;
	import vbl_pkg::*;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	char_s        rx = '0;
	logic         rx_ready;
	char_s        tx;
	logic         tx_ready = 1'b0;
	card_req_s    req;
	card_rsp_s    rsp;
	login_s       login;
	logic [7:0]   delay = 8'h00;
	card_status_e st = CS_OK;
	logic         corrupt = 1'b0;
	logic [63:0]  rep;
	int           fails = 0;
	int           samples_checked = 0;

	always #4 clk = ~clk;

	value_block_and_sector_login i_dut (.i_clk(clk), .i_resetn(resetn), .i_rx(rx),
		.o_rx_ready(rx_ready), .o_tx(tx), .i_tx_ready(tx_ready), .o_card_req(req),
		.i_card_rsp(rsp), .o_login(login));
	card_model i_card (.i_clk(clk), .i_req(req), .o_rsp(rsp), .i_delay(delay),
		.i_status(st), .i_corrupt(corrupt));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a wait that runs out counts against the run and closes it
	task automatic hang();
		fails++;
		$display("wrong value handshake expected 1 seen 0");
		end_of_test();
	endtask
	// eight hex chars of a value, top nibble first
	function automatic logic [63:0] hex8(input logic [31:0] v);
		logic [3:0] d;
		for (int i = 0; i < 8; i++)
		begin
			d = v[31-4*i -: 4];
			hex8[63-8*i -: 8] = (d < 4'hA) ? 8'h30 + d : 8'h37 + d;
		end
	endfunction
	// value block image: value, inverse, value, address pattern
	function automatic logic [127:0] vimg(input logic [31:0] v, input logic [7:0] a);
		return {~a, a, ~a, a, v, ~v, v};
	endfunction
	// one char per two cycles, only while the handler listens
	task automatic send(input string s);
		int n;
		for (int i = 0; i < s.len(); i++)
		begin
			n = 0;
			while (rx_ready !== 1'b1)
			begin
				@(posedge clk);
				#1;
				if (++n > 3000) hang();
			end
			rx.valid = 1'b1;
			rx.data  = s[i];
			@(posedge clk);
			#1;
			rx = '0;
			@(posedge clk);
			#1;
		end
	endtask
	// takes n reply chars, stalling each for a cycle first
	task automatic recv(input int n);
		int k;
		rep = '0;
		for (int i = 0; i < n; i++)
		begin
			k = 0;
			while (tx.valid !== 1'b1)
			begin
				@(posedge clk);
				#1;
				if (++k > 3000) hang();
			end
			@(posedge clk);
			#1;
			tx_ready = 1'b1;
			rep = {rep[55:0], tx.data};
			@(posedge clk);
			#1;
			tx_ready = 1'b0;
		end
	endtask
	// a reply may start before all chars are out, so both run together
	task automatic cmd(input string s, input int n, input logic [63:0] e);
		fork
			send(s);
			recv(n);
		join
		`CHK(s, e, rep)
		repeat (3) @(posedge clk);
		#1;
		`CHK("extra reply char", 1'b0, tx.valid)
	endtask

	task automatic t_login();
		string       s [8] = '{"l02AA\015", "L3FBB\015", "l04FF\015", "l0FAA112233445566",
			"L0E14", "l0732", "L054F", "l0110"};
		logic [5:0]  sec [8] = '{6'h02, 6'h3F, 6'h04, 6'h0F, 6'h0E, 6'h07, 6'h05, 6'h01};
		logic [47:0] key [4] = '{TKEY_A, TKEY_B, TKEY_ONES, 48'h112233445566};
		logic [4:0]  idx [4] = '{5'h04, 5'h02, 5'h1F, 5'h00};
		logic [7:0]  kb = 8'b01000110;
		logic [7:0]  ks = 8'b00001111;
		for (int i = 0; i < 8; i++)
		begin
			cmd(s[i], 1, {56'h0, RSP_LOGIN_OK});
			`CHK("auth op", OP_AUTH, i_card.last.op)
			`CHK("sector", {2'b00, sec[i]}, i_card.last.block)
			`CHK("key b", kb[7-i], i_card.last.key_b)
			`CHK("stored", ks[7-i], i_card.last.key_stored)
			if (i < 4)
				`CHK("key", key[i], i_card.last.key)
			else
				`CHK("key index", idx[i-4], i_card.last.key_index)
			`CHK("login", {1'b1, sec[i]}, login)
		end
	endtask

	task automatic t_login_err();
		string        s [3] = '{"l40AA\015", "l0150", "l010F"};
		card_status_e cs [4] = '{CS_AUTH_FAIL, CS_NO_TAG, CS_NOT_A, CS_FAIL};
		logic [7:0]   r [4] = '{RSP_AUTH_FAIL, RSP_NO_TAG, RSP_OP_MODE, RSP_FAIL};
		int           n;
		for (int i = 0; i < 3; i++)
		begin
			n = i_card.nreq;
			cmd(s[i], 1, {56'h0, RSP_RANGE});
			`CHK("card untouched", n, i_card.nreq)
		end
		for (int i = 0; i < 4; i++)
		begin
			st = cs[i];
			cmd("l0210", 1, {56'h0, r[i]});
			`CHK("login dropped", 1'b0, login.valid)
		end
		st = CS_OK;
	endtask

	task automatic t_value();
		i_card.mem[5] = vimg(32'h10, 8'h05);
		delay = 8'h14;
		cmd("+050000ff00", 8, hex8(32'hFF10));
		`CHK("inc image", vimg(32'hFF10, 8'h05), i_card.mem[5])
		delay = 8'h00;
		i_card.mem[4] = vimg(32'h0, 8'h04);
		cmd("-0400000001", 8, hex8(32'hFFFFFFFF));
		`CHK("dec image", vimg(32'hFFFFFFFF, 8'h04), i_card.mem[4])
		i_card.mem[6] = 128'h5;
		cmd("=0406", 8, hex8(32'hFFFFFFFF));
		`CHK("copy image", vimg(32'hFFFFFFFF, 8'h06), i_card.mem[6])
	endtask

	task automatic t_value_err();
		string c [3] = '{"+0700000001", "-0700000001", "=0708"};
		for (int i = 0; i < 3; i++)
		begin
			i_card.mem[7] = vimg(32'h5, 8'h07) ^ 128'h1;
			cmd(c[i], 1, {56'h0, RSP_NO_VALUE});
			i_card.mem[7] = vimg(32'h5, 8'h07);
			corrupt = 1'b1;
			cmd(c[i], 1, {56'h0, RSP_FAIL});
			corrupt = 1'b0;
			st = CS_NO_TAG;
			cmd(c[i], 1, {56'h0, RSP_NO_TAG});
			st = CS_NOT_A;
			cmd(c[i], 1, {56'h0, RSP_OP_MODE});
			st = CS_FAIL;
			cmd(c[i], 1, {56'h0, RSP_FAIL});
			st = CS_OK;
		end
	endtask

	// reset, log in first, then the value commands
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		t_login();
		t_login_err();
		t_value();
		t_value_err();
		end_of_test();
	end
endmodule
